// [inc/rss_cfg.svh]
/*
 * Constants for the reset sources sequencer: register offsets, field
 * positions and timing counts. Assumes a 250 MHz system clock.
 */
`ifndef RSS_CFG_SVH
`define RSS_CFG_SVH

`define RSS_CLK_MHZ 250
// Register byte offsets on the Avalon-MM slave
`define RSS_OFS_HARDWARE_CONFIG 4'h0
`define RSS_OFS_POWER_MGMT_CONTROL 4'h4
`define RSS_OFS_WAKE_TEST 4'h8
`define RSS_OFS_PHY_BCR 4'hc
// Field positions
`define RSS_SOFT_RESET_BIT 0
`define RSS_PHY_RST_BIT 10
`define RSS_READY_BIT 0
`define RSS_PM_MODE_LO 12
`define RSS_PHY_BCR_RST_BIT 15
`define RSS_EEPROM_BUSY_BIT 31
`define RSS_PROT_LO 8
// Times in their own units
`define RSS_POR_TIME_US 22000
`define RSS_SOFT_RESET_TIME_NS 2000
`define RSS_PHY_RESET_TIME_US 100
`define RSS_WAKE_TIME_US 2000
`define RSS_PHY_BCR_TIME_US 100
`define RSS_EEPROM_PROBE_TIME_US 10
// Cycle counts derived from the times (the wake count is half its time)
`define RSS_POR_CYCLES (`RSS_POR_TIME_US * `RSS_CLK_MHZ)
`define RSS_SOFT_RESET_CYCLES (`RSS_SOFT_RESET_TIME_NS * `RSS_CLK_MHZ / 1000)
`define RSS_PHY_RESET_CYCLES (`RSS_PHY_RESET_TIME_US * `RSS_CLK_MHZ)
`define RSS_WAKE_CYCLES (`RSS_WAKE_TIME_US * `RSS_CLK_MHZ / 2)
`define RSS_PHY_BCR_CYCLES (`RSS_PHY_BCR_TIME_US * `RSS_CLK_MHZ)
`define RSS_EEPROM_PROBE_CYCLES (`RSS_EEPROM_PROBE_TIME_US * `RSS_CLK_MHZ)

`endif

// [inc/rss_pkg.sv]
/*
 * Types for the reset sources sequencer.
 * Assumes rss_cfg.svh for all numeric constants.
 */
package rss_pkg;
    typedef enum logic [3:0] {
        RSS_CHIP_RESET = 4'h1,
        RSS_SOFT_RESET = 4'h2,
        RSS_EEPROM_PROBE = 4'h4,
        RSS_RUN = 4'h8
    } rss_state_e;
    typedef logic [23:0] rss_count_t;
endpackage : rss_pkg

// [rtl/rss_reset_sequencer.sv]
/*
 * Reset sources sequencer: combines power-on, pin, soft and transceiver
 * resets, drives the reset of each internal circuit, times self-clearing
 * bits and the ready flag. Assumes synchronous inputs bar the reset pin, a 250 MHz clock
 * and a host on Avalon-MM with waitrequest.
 */
// Our own choices: the address map and the Avalon-MM interface to the registers.
`include "rss_cfg.svh"
`timescale 1ns/100ps
module rss_reset_sequencer
    import rss_pkg::*;
#(
    parameter int POR_CYCLES = `RSS_POR_CYCLES,
    parameter int PHY_RESET_CYCLES = `RSS_PHY_RESET_CYCLES,
    parameter int WAKE_CYCLES = `RSS_WAKE_CYCLES,
    parameter int PHY_BCR_CYCLES = `RSS_PHY_BCR_CYCLES
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic hw_reset_pin_n,
    input wire logic eeprom_present,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic pll_reset,
    output logic host_bus_interface_reset,
    output logic soft_reset_protected_reset,
    output logic mii_reset,
    output logic mac_reset,
    output logic phy_reset,
    output logic mac_address_reload,
    output logic strap_latch
);

    // Power-on reset is modelled by rst_n; the pin is a second async source
    // Two flops keep the pin release clean; its assertion takes effect at once
    logic pin_sync1;
    logic pin_sync2;
    always_ff @(posedge sys_clk or negedge rst_n or negedge hw_reset_pin_n) begin
        if (!rst_n || !hw_reset_pin_n) begin
            pin_sync1 <= 1'b0;
            pin_sync2 <= 1'b0;
        end else begin
            pin_sync1 <= 1'b1;
            pin_sync2 <= pin_sync1;
        end
    end
    logic chip_rst_n;
    assign chip_rst_n = pin_sync2;

    rss_state_e state;
    rss_state_e next_state;
    rss_count_t seq_count;
    rss_count_t next_seq_count;
    rss_count_t phy_count;
    rss_count_t next_phy_count;
    logic from_por;
    logic next_from_por;
    logic ready;
    logic next_ready;
    logic soft_reset_request;
    logic next_soft_reset_request;
    logic phy_rst_bit;
    logic next_phy_rst_bit;
    logic phy_bcr_rst;
    logic next_phy_bcr_rst;
    logic [1:0] pm_mode;
    logic [1:0] next_pm_mode;
    logic waking;
    logic next_waking;
    logic [7:0] prot_field;
    logic [7:0] next_prot_field;
    logic eeprom_ctrl_busy;
    logic next_eeprom_ctrl_busy;
    logic [31:0] next_readdata;
    logic next_waitrequest;
    logic wr_hit;
    logic rd_hit;

    // One-cycle waitrequest: a request is accepted on its second cycle.
    // A write lands at the edge where waitrequest is seen low; read data are
    // captured one edge earlier so that they stand at that edge.
    assign wr_hit = avs_write && !avs_waitrequest;
    assign rd_hit = avs_read && avs_waitrequest;

    function automatic logic hit(input logic [3:0] addr, input logic [3:0] ofs);
        hit = (addr == ofs);
    endfunction : hit

    always_comb begin
        next_state = state;
        next_seq_count = seq_count;
        next_phy_count = phy_count;
        // Only the first chip reset after power-on runs the long timer
        next_from_por = from_por && (state == RSS_CHIP_RESET);
        next_ready = ready;
        next_soft_reset_request = soft_reset_request;
        next_phy_rst_bit = phy_rst_bit;
        next_phy_bcr_rst = phy_bcr_rst;
        next_pm_mode = pm_mode;
        next_waking = waking;
        next_prot_field = prot_field;
        next_eeprom_ctrl_busy = eeprom_ctrl_busy;
        next_waitrequest = !(avs_read || avs_write) || !avs_waitrequest;
        next_readdata = 32'h0000_0000;
        unique case (state)
            RSS_CHIP_RESET: begin
                next_ready = 1'b0;
                if (!from_por || seq_count >= rss_count_t'(POR_CYCLES - 1)) begin
                    next_state = RSS_EEPROM_PROBE;
                    next_seq_count = '0;
                    next_eeprom_ctrl_busy = eeprom_present;
                end else begin
                    next_seq_count = seq_count + 1'b1;
                end
            end
            RSS_SOFT_RESET: begin
                // Ready stays low until the soft reset has run its course
                next_ready = 1'b0;
                if (seq_count >= rss_count_t'(`RSS_SOFT_RESET_CYCLES - 1)) begin
                    next_soft_reset_request = 1'b0;
                    next_ready = 1'b1;
                    next_state = RSS_EEPROM_PROBE;
                    next_seq_count = '0;
                    next_eeprom_ctrl_busy = eeprom_present;
                end else begin
                    next_seq_count = seq_count + 1'b1;
                end
            end
            RSS_EEPROM_PROBE: begin
                // Ready rises while the probe runs; software watches the busy bit
                next_ready = 1'b1;
                if (!eeprom_ctrl_busy || seq_count >= rss_count_t'(`RSS_EEPROM_PROBE_CYCLES - 1)) begin
                    next_eeprom_ctrl_busy = 1'b0;
                    next_state = RSS_RUN;
                end else begin
                    next_seq_count = seq_count + 1'b1;
                end
            end
            RSS_RUN: begin
                // The wake delay reuses seq_count, free once chip resets are done
                if (waking) begin
                    if (seq_count >= rss_count_t'(WAKE_CYCLES - 1)) begin
                        next_waking = 1'b0;
                        next_ready = 1'b1;
                    end else begin
                        next_seq_count = seq_count + 1'b1;
                    end
                end
            end
        endcase
        // Transceiver-only reset timers, shared counter for both bits
        // Limitation: starting the second bit restarts the count of the first
        if (phy_rst_bit || phy_bcr_rst) begin
            if (phy_rst_bit && phy_count >= rss_count_t'(PHY_RESET_CYCLES - 1)) begin
                next_phy_rst_bit = 1'b0;
            end
            if (phy_bcr_rst && phy_count >= rss_count_t'(PHY_BCR_CYCLES - 1)) begin
                next_phy_bcr_rst = 1'b0;
            end
            next_phy_count = phy_count + 1'b1;
        end else begin
            next_phy_count = '0;
        end
        if (wr_hit) begin
            if (pm_mode != 2'b00) begin
                // Asleep: only the wake-test write has any effect
                if (hit(avs_address, `RSS_OFS_WAKE_TEST)) begin
                    next_pm_mode = 2'b00;
                    next_waking = 1'b1;
                    next_ready = 1'b0;
                    next_seq_count = '0;
                end
            end else if (state == RSS_RUN && !waking) begin
                if (hit(avs_address, `RSS_OFS_HARDWARE_CONFIG)) begin
                    next_prot_field = avs_writedata[`RSS_PROT_LO +: 8];
                    if (avs_writedata[`RSS_SOFT_RESET_BIT]) begin
                        next_soft_reset_request = 1'b1;
                        next_ready = 1'b0;
                        next_state = RSS_SOFT_RESET;
                        next_seq_count = '0;
                    end
                end
                // Entering sleep drops ready; only a wake-test write or a chip reset brings it back
                if (hit(avs_address, `RSS_OFS_POWER_MGMT_CONTROL)) begin
                    next_pm_mode = avs_writedata[`RSS_PM_MODE_LO +: 2];
                    if (avs_writedata[`RSS_PM_MODE_LO +: 2] != 2'b00) begin
                        next_ready = 1'b0;
                    end
                    if (avs_writedata[`RSS_PHY_RST_BIT] && !phy_rst_bit) begin
                        next_phy_rst_bit = 1'b1;
                        next_phy_count = '0;
                    end
                end
                if (hit(avs_address, `RSS_OFS_PHY_BCR) && avs_writedata[`RSS_PHY_BCR_RST_BIT] && !phy_bcr_rst) begin
                    next_phy_bcr_rst = 1'b1;
                    next_phy_count = '0;
                end
            end
        end
        if (rd_hit) begin
            if (hit(avs_address, `RSS_OFS_HARDWARE_CONFIG)) begin
                next_readdata[`RSS_SOFT_RESET_BIT] = soft_reset_request;
                next_readdata[`RSS_PROT_LO +: 8] = prot_field;
                next_readdata[`RSS_EEPROM_BUSY_BIT] = eeprom_ctrl_busy;
            end else if (hit(avs_address, `RSS_OFS_POWER_MGMT_CONTROL)) begin
                next_readdata[`RSS_READY_BIT] = ready;
                next_readdata[`RSS_PHY_RST_BIT] = phy_rst_bit;
                next_readdata[`RSS_PM_MODE_LO +: 2] = pm_mode;
            end else if (hit(avs_address, `RSS_OFS_PHY_BCR)) begin
                next_readdata[`RSS_PHY_BCR_RST_BIT] = phy_bcr_rst;
            end
        end
    end

    // Pin and power-on resets clear all state but from_por, including protected bits
    always_ff @(posedge sys_clk or negedge chip_rst_n) begin
        if (!chip_rst_n) begin
            state <= RSS_CHIP_RESET;
            seq_count <= '0;
            phy_count <= '0;
            ready <= 1'b0;
            soft_reset_request <= 1'b0;
            phy_rst_bit <= 1'b0;
            phy_bcr_rst <= 1'b0;
            pm_mode <= 2'b00;
            waking <= 1'b0;
            prot_field <= 8'h00;
            eeprom_ctrl_busy <= 1'b0;
            avs_readdata <= 32'h0000_0000;
            avs_waitrequest <= 1'b1;
        end else begin
            state <= next_state;
            seq_count <= next_seq_count;
            phy_count <= next_phy_count;
            ready <= next_ready;
            soft_reset_request <= next_soft_reset_request;
            phy_rst_bit <= next_phy_rst_bit;
            phy_bcr_rst <= next_phy_bcr_rst;
            pm_mode <= next_pm_mode;
            waking <= next_waking;
            prot_field <= next_prot_field;
            eeprom_ctrl_busy <= next_eeprom_ctrl_busy;
            avs_readdata <= next_readdata;
            avs_waitrequest <= next_waitrequest;
        end
    end

    // Only power-on extends the reset to 22 ms; a pin reset releases at once.
    // Reset by rst_n alone, so a pin reset during the power-on hold keeps it.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            from_por <= 1'b1;
        end else begin
            from_por <= next_from_por;
        end
    end

    // Per-circuit reset outputs, registered
    // Taken from the next state so that each output comes straight from a flop
    always_ff @(posedge sys_clk or negedge chip_rst_n) begin
        if (!chip_rst_n) begin
            pll_reset <= 1'b1;
            host_bus_interface_reset <= 1'b1;
            soft_reset_protected_reset <= 1'b1;
            mii_reset <= 1'b1;
            mac_reset <= 1'b1;
            phy_reset <= 1'b1;
            mac_address_reload <= 1'b0;
            strap_latch <= 1'b0;
        end else begin
            pll_reset <= (next_state == RSS_CHIP_RESET);
            soft_reset_protected_reset <= (next_state == RSS_CHIP_RESET);
            host_bus_interface_reset <= (next_state == RSS_CHIP_RESET) || (next_state == RSS_SOFT_RESET);
            mii_reset <= (next_state == RSS_CHIP_RESET) || (next_state == RSS_SOFT_RESET);
            mac_reset <= (next_state == RSS_CHIP_RESET) || (next_state == RSS_SOFT_RESET);
            phy_reset <= (next_state == RSS_CHIP_RESET) || next_phy_rst_bit || next_phy_bcr_rst;
            mac_address_reload <= (state != RSS_EEPROM_PROBE) && (next_state == RSS_EEPROM_PROBE)
                && eeprom_present;
            strap_latch <= (state == RSS_CHIP_RESET) && (next_state != RSS_CHIP_RESET);
        end
    end

endmodule : rss_reset_sequencer

// [tb/rss_reset_sequencer_checker.sv]
/* Port checker for the reset sources sequencer, bound to its top module.
   Assumes one clock domain, sys_clk, with rst_n as its reset. */
`timescale 1ns/100ps
module rss_reset_sequencer_checker (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic hw_reset_pin_n,
    input wire logic eeprom_present,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic pll_reset,
    input wire logic host_bus_interface_reset,
    input wire logic soft_reset_protected_reset,
    input wire logic mii_reset,
    input wire logic mac_reset,
    input wire logic phy_reset,
    input wire logic mac_address_reload
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    chk_pin_async: assert property (
        !hw_reset_pin_n |-> pll_reset && soft_reset_protected_reset) else $error("pin reset not applied");
    chk_chip_all: assert property (
        pll_reset |-> host_bus_interface_reset && mii_reset && mac_reset && phy_reset) else $error("chip reset partial");
    chk_soft_group: assert property (
        mac_reset == mii_reset && mii_reset == host_bus_interface_reset) else $error("soft reset group split");
    chk_prot_pair: assert property (
        soft_reset_protected_reset == pll_reset) else $error("protected reset not tied to chip reset");
    chk_wait_one: assert property (
        $rose(avs_read || avs_write) |=> !avs_waitrequest) else $error("bus answer late");
    chk_wait_single: assert property (
        !avs_waitrequest |=> avs_waitrequest) else $error("bus answer too long");
    chk_rdata_idle: assert property (
        avs_waitrequest |-> avs_readdata == 32'h0) else $error("read data outside answer");
    chk_reload_pulse: assert property (
        mac_address_reload |-> eeprom_present && !pll_reset ##1 !mac_address_reload) else $error("bad reload pulse");
endmodule : rss_reset_sequencer_checker

bind rss_reset_sequencer rss_reset_sequencer_checker u_chk (.sys_clk(sys_clk), .rst_n(rst_n),
    .hw_reset_pin_n(hw_reset_pin_n), .eeprom_present(eeprom_present), .avs_read(avs_read), .avs_write(avs_write),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .pll_reset(pll_reset),
    .host_bus_interface_reset(host_bus_interface_reset), .soft_reset_protected_reset(soft_reset_protected_reset),
    .mii_reset(mii_reset), .mac_reset(mac_reset), .phy_reset(phy_reset), .mac_address_reload(mac_address_reload));

// [tb/rss_host_model.sv]
/* Host processor model: Avalon-MM master with word read and write tasks.
   Assumes tasks are called just after a rising edge of sys_clk. */
`timescale 1ns/100ps
module rss_host_model (
    input wire logic sys_clk,
    input wire logic avs_waitrequest,
    input wire logic [31:0] avs_readdata,
    output logic [3:0] avs_address,
    output logic avs_read,
    output logic avs_write,
    output logic [31:0] avs_writedata
);
    initial begin
        avs_address = 4'h0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
    end
    // Released lines show the inverse so stale values are never mistaken for data
    task wr(input logic [3:0] a, input logic [31:0] v);
        avs_address <= a;
        avs_writedata <= v;
        avs_write <= 1'b1;
        do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
        avs_write <= 1'b0;
        avs_writedata <= ~v;
        @(posedge sys_clk);
    endtask : wr
    task rd(input logic [3:0] a, output logic [31:0] v);
        avs_address <= a;
        avs_read <= 1'b1;
        do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
        v = avs_readdata;
        avs_read <= 1'b0;
        avs_address <= ~a;
        @(posedge sys_clk);
    endtask : rd
endmodule : rss_host_model

// [tb/rss_reset_sequencer_tb.sv]
/* Self-checking bench for the reset sources sequencer.
   Assumes shortened counts set below; soft reset and probe keep their defaults. */
`timescale 1ns/100ps
module rss_reset_sequencer_tb;
    import rss_pkg::*;
    localparam int POR = 20, PHYR = 20, WAKE = 30, BCR = 20;
    logic sys_clk, rst_n, hw_reset_pin_n, eeprom_present, avs_read, avs_write, avs_waitrequest;
    logic [3:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, d;
    logic pll_reset, bus_if_rst, prot_rst, mii_reset, mac_reset, phy_reset, mac_address_reload, strap_latch;
    int n_fail = 0, cmp_count = 0, seed = 84, cyc = 0, t0, exp_prot = 0, n_strap = 0, n_reload = 0;
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) cyc <= cyc + 1;
    // Pulse counters: the expected counts follow from the reset sources used below
    always @(posedge sys_clk) begin
        n_strap <= n_strap + int'(strap_latch);
        n_reload <= n_reload + int'(mac_address_reload);
    end
    rss_reset_sequencer #(.POR_CYCLES(POR), .PHY_RESET_CYCLES(PHYR), .WAKE_CYCLES(WAKE), .PHY_BCR_CYCLES(BCR)) u_dut (
        .sys_clk(sys_clk), .rst_n(rst_n), .hw_reset_pin_n(hw_reset_pin_n), .eeprom_present(eeprom_present),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .pll_reset(pll_reset),
        .host_bus_interface_reset(bus_if_rst), .soft_reset_protected_reset(prot_rst), .mii_reset(mii_reset),
        .mac_reset(mac_reset), .phy_reset(phy_reset), .mac_address_reload(mac_address_reload), .strap_latch(strap_latch));
    rss_host_model u_host (.sys_clk(sys_clk), .avs_waitrequest(avs_waitrequest), .avs_readdata(avs_readdata),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata));
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %0t %s", $time, msg);
        end
    endtask : check
    // Polls a bit until it reaches v, then checks the elapsed cycles lie in lo..hi
    task automatic poll(input logic [3:0] a, input int b, input logic v, input int lo, input int hi);
        t0 = cyc;
        do u_host.rd(a, d); while (d[b] !== v && cyc - t0 <= hi);
        check(cyc - t0 >= lo && cyc - t0 <= hi, 1, "wait out of range");
    endtask : poll
    task summarize;
        $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : summarize
    initial begin
        repeat (40000) @(posedge sys_clk);
        n_fail++;
        $display("ERROR %0t watchdog expired", $time);
        summarize;
    end
    initial begin
        rst_n = 1'b0;
        hw_reset_pin_n = 1'b1;
        eeprom_present = 1'b1;
        repeat (20) @(posedge sys_clk);
        rst_n <= 1'b1;
        // Let the pin synchroniser release before the first request
        repeat (3) @(posedge sys_clk);
        u_host.rd(4'h4, d);
        check(d[0], 0, "ready during power-on");
        check(pll_reset, 1, "power-on hold too short");
        poll(4'h4, 0, 1, 0, POR + 12);
        poll(4'h0, 31, 0, 2400, 2600);
        $display("power-on test done");
        exp_prot = $random(seed) & 8'hff;
        u_host.wr(4'h0, 32'(exp_prot) << 8);
        u_host.wr(4'h0, (32'(exp_prot) << 8) | 32'h1);
        repeat (3) @(posedge sys_clk);
        check({mac_reset, mii_reset, bus_if_rst}, 3'b111, "soft reset group");
        check({prot_rst, pll_reset, phy_reset}, 3'b000, "soft reset spared");
        u_host.rd(4'h4, d);
        check(d[0], 0, "ready during soft reset");
        poll(4'h0, 0, 0, 485, 515);
        u_host.rd(4'h0, d);
        check(d[15:8], exp_prot[7:0], "protected field lost");
        check(d[31], 1, "no probe after soft reset");
        u_host.rd(4'h4, d);
        check(d[0], 1, "ready after soft reset");
        poll(4'h0, 31, 0, 2300, 2600);
        $display("soft reset test done");
        for (int i = 0; i < 2; i++) begin
            u_host.wr(i ? 4'hc : 4'h4, i ? 32'h8000 : 32'h400);
            repeat (3) @(posedge sys_clk);
            check({phy_reset, mac_reset, pll_reset}, 3'b100, "transceiver reset scope");
            poll(i ? 4'hc : 4'h4, i ? 15 : 10, 0, (i ? BCR : PHYR) - 10, (i ? BCR : PHYR) + 10);
        end
        $display("transceiver reset test done");
        for (int m = 1; m < 4; m++) begin
            u_host.wr(4'h4, 32'(m) << 12);
            u_host.rd(4'h4, d);
            check(d[0], 0, "ready in sleep");
            u_host.wr(4'h8, $random(seed));
            poll(4'h4, 0, 1, WAKE - 8, WAKE + 10);
        end
        $display("wake test done");
        eeprom_present <= 1'b0;
        hw_reset_pin_n <= 1'b0;
        #1;
        check(pll_reset, 1, "pin reset not immediate");
        repeat (3) @(posedge sys_clk);
        hw_reset_pin_n <= 1'b1;
        @(posedge sys_clk);
        check(mac_reset, 1, "pin reset released early");
        repeat (3) @(posedge sys_clk);
        poll(4'h4, 0, 1, 0, 12);
        u_host.rd(4'h0, d);
        check({d[31], d[15:8]}, 9'h0, "pin reset left state");
        $display("pin reset test done");
        check(n_strap, 2, "strap latch count");
        check(n_reload, 2, "address reload count");
        summarize;
    end
endmodule : rss_reset_sequencer_tb
